// [hsf_pkg.sv]
package hsf_pkg;

    // ------------------------------------------------------------------
    // Channels: index 0 is the heater switch, 1 to 4 are the lamp switches.
    // ------------------------------------------------------------------
    localparam int NUM_OUT = 5;
    localparam int NUM_EVT = 2 * NUM_OUT;

    // ------------------------------------------------------------------
    // Time base: a 1 us enable pulse from the 20 MHz reference clock.
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int TICK_NS       = 1000;
    localparam int TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
    localparam int TICK_W        = 5;

    // Qualification times in microseconds, each inside its allowed band.
    localparam int HEATER_SD_US = 25;
    localparam int LAMP_SON_US  = 200;
    localparam int LAMP_ON_US   = 25;
    localparam int OL_FILT_US   = 100;

    // The same times as counts of 1 us ticks.
    localparam int HEATER_SD_TICKS = HEATER_SD_US * 1000 / TICK_NS;
    localparam int LAMP_SON_TICKS  = LAMP_SON_US * 1000 / TICK_NS;
    localparam int LAMP_ON_TICKS   = LAMP_ON_US * 1000 / TICK_NS;
    localparam int OL_FILT_TICKS   = OL_FILT_US * 1000 / TICK_NS;
    localparam int QUAL_W          = 9;

    // ------------------------------------------------------------------
    // Register byte offsets on the bus.
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_PULLUP   = 8'h04;
    localparam logic [7:0] OFS_FAULT    = 8'h08;
    localparam logic [7:0] OFS_CLEAR    = 8'h0C;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
    localparam logic [7:0] OFS_LIVE     = 8'h18;

    // Field positions and values after reset.
    localparam int CLEAR_BIT    = 0;
    localparam int OPEN_LSB     = NUM_OUT;
    localparam logic [NUM_OUT-1:0] CTRL_RST   = 5'h00;
    localparam logic [NUM_OUT-1:0] PULLUP_RST = 5'h1F;
    localparam logic [NUM_EVT-1:0] MASK_RST   = 10'h000;

    // Protection state of one switch.
    typedef enum logic [3:0] {
        ST_OFF   = 4'h1,
        ST_START = 4'h2,
        ST_ON    = 4'h4,
        ST_FAULT = 4'h8
    } hsf_state_t;

endpackage

// [hsf_channel.sv]
`timescale 1ns/1ps
`default_nettype none
module hsf_channel
    import hsf_pkg::*;
#(
    parameter bit IS_LAMP   = 1'b0,
    parameter int ON_TICKS  = HEATER_SD_TICKS,
    parameter int SON_TICKS = LAMP_SON_TICKS
) (
    input  wire logic ref_clk,
    input  wire logic resetn,
    input  wire logic tick,
    input  wire logic cmd_on,
    input  wire logic over_current,
    input  wire logic volt_low,
    input  wire logic fault_clear,
    output logic      switch_on,
    output logic      short_fault,
    output logic      short_event
);

    localparam logic [QUAL_W-1:0] ON_LIM  = QUAL_W'(ON_TICKS);
    localparam logic [QUAL_W-1:0] SON_LIM = QUAL_W'(SON_TICKS);

    hsf_state_t        state_r, state_nxt;
    logic [QUAL_W-1:0] qual_r, qual_nxt;
    logic [QUAL_W-1:0] age_r, age_nxt;
    logic              sw_r, sw_nxt;
    logic              ev_r, ev_nxt;
    logic              cond;

    // ------------------------------------------------------------------
    // Next state: qualification counter and switch state machine.
    // ------------------------------------------------------------------
    always_comb begin
        // At switch-on a lamp short needs high current and low voltage.
        cond = (state_r == ST_START) ? (over_current & volt_low)
                                     : over_current;
        state_nxt = state_r;
        age_nxt   = age_r;
        ev_nxt    = 1'b0;
        // A gap in the fault restarts the wait from zero.
        if (!cond || state_r == ST_OFF || state_r == ST_FAULT) begin
            qual_nxt = '0;
        end else if (tick && qual_r != SON_LIM) begin
            qual_nxt = qual_r + 1'b1;
        end else begin
            qual_nxt = qual_r;
        end
        if (tick && state_r == ST_START && age_r != SON_LIM) begin
            age_nxt = age_r + 1'b1;
        end
        unique case (state_r)
            ST_OFF: begin
                age_nxt = '0;
                if (cmd_on) begin
                    state_nxt = IS_LAMP ? ST_START : ST_ON;
                end
            end
            ST_START: begin
                if (qual_r >= SON_LIM) begin
                    state_nxt = ST_FAULT;
                    ev_nxt    = 1'b1;
                end else if (!cmd_on) begin
                    state_nxt = ST_OFF;
                end else if (age_r >= SON_LIM) begin
                    state_nxt = ST_ON;
                end
            end
            ST_ON: begin
                // Fault is checked first so a late off request still logs it.
                if (qual_r >= ON_LIM) begin
                    state_nxt = ST_FAULT;
                    ev_nxt    = 1'b1;
                end else if (!cmd_on) begin
                    state_nxt = ST_OFF;
                end
            end
            ST_FAULT: begin
                // Latched off until the status reset command.
                if (fault_clear) begin
                    state_nxt = ST_OFF;
                end
            end
            default: begin
                state_nxt = ST_OFF;
            end
        endcase
        sw_nxt = (state_nxt == ST_START) || (state_nxt == ST_ON);
    end

    // ------------------------------------------------------------------
    // State registers.
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            state_r <= ST_OFF;
            qual_r  <= '0;
            age_r   <= '0;
            sw_r    <= 1'b0;
            ev_r    <= 1'b0;
        end else begin
            state_r <= state_nxt;
            qual_r  <= qual_nxt;
            age_r   <= age_nxt;
            sw_r    <= sw_nxt;
            ev_r    <= ev_nxt;
        end
    end

    assign switch_on   = sw_r;
    assign short_fault = (state_r == ST_FAULT);
    assign short_event = ev_r;

endmodule
`default_nettype wire

// [hsf_supervisor.sv]
// Notes on behaviour
// - One heater and four lamp switches supervised.
// - Heater over-current held 25 us: switch off, flag.
// - Heater fault holds until status reset command.
// - Lamp start short (current, low voltage) 200 us.
// - Lamp on-state over-current 25 us: off, flag.
// - Off-state voltage above threshold raises open-load.
// - Open-load bit latched until status reset.
// - Pull-up current follows each output's enable bit.
//
// The AHB-Lite register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module hsf_supervisor
    import hsf_pkg::*;
#(
    parameter int N_OUT = NUM_OUT
) (
    input  wire logic             ref_clk,
    input  wire logic             resetn,
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic             hready,
    input  wire logic [31:0]      hwdata,
    output logic      [31:0]      hrdata,
    output logic                  hreadyout,
    output logic                  hresp,
    input  wire logic [N_OUT-1:0] over_current,
    input  wire logic [N_OUT-1:0] short_volt_low,
    input  wire logic [N_OUT-1:0] open_load_above,
    output logic      [N_OUT-1:0] switch_enable,
    output logic      [N_OUT-1:0] open_load_pullup_enable,
    output logic                  irq
);

    // ------------------------------------------------------------------
    // Declarations.
    // ------------------------------------------------------------------
    logic [TICK_W-1:0]  div_r, div_nxt;
    logic               tick_r, tick_nxt;
    logic               wr_pend_r, wr_pend_nxt;
    logic [7:0]         wr_addr_r, wr_addr_nxt;
    logic [N_OUT-1:0]   ctrl_r, ctrl_nxt;
    logic [N_OUT-1:0]   pullup_r, pullup_nxt;
    logic [N_OUT-1:0]   ol_r, ol_nxt;
    logic [NUM_EVT-1:0] istat_r, istat_nxt;
    logic [NUM_EVT-1:0] mask_r, mask_nxt;
    logic [NUM_EVT-1:0] w1c;
    logic               clr_r, clr_nxt;
    logic               irq_r, irq_nxt;
    logic [31:0]        rdata_r, rdata_nxt;
    logic               rdy_r;
    logic               resp_r;
    logic [N_OUT-1:0]   sw;
    logic [N_OUT-1:0]   sc_fault;
    logic [N_OUT-1:0]   sc_event;
    logic [N_OUT-1:0]   ol_set;
    logic               ap_valid;

    // ------------------------------------------------------------------
    // Time base.
    // ------------------------------------------------------------------

    // One pulse per microsecond drives every qualification counter.
    always_comb begin
        tick_nxt = (div_r == TICK_W'(TICK_CYC - 1));
        div_nxt  = tick_nxt ? '0 : div_r + 1'b1;
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            div_r  <= '0;
            tick_r <= 1'b0;
        end else begin
            div_r  <= div_nxt;
            tick_r <= tick_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Short-circuit protection, one channel per switch.
    // ------------------------------------------------------------------

    // Channel 0 is the heater; the lamps add the switch-on check.
    for (genvar i = 0; i < N_OUT; i++) begin : g_ch
        hsf_channel #(
            .IS_LAMP   (i != 0),
            .ON_TICKS  ((i == 0) ? HEATER_SD_TICKS : LAMP_ON_TICKS),
            .SON_TICKS (LAMP_SON_TICKS)
        ) u_ch (
            .ref_clk      (ref_clk),
            .resetn       (resetn),
            .tick         (tick_r),
            .cmd_on       (ctrl_r[i]),
            .over_current (over_current[i]),
            .volt_low     (short_volt_low[i]),
            .fault_clear  (clr_r),
            .switch_on    (sw[i]),
            .short_fault  (sc_fault[i]),
            .short_event  (sc_event[i])
        );
    end

    // ------------------------------------------------------------------
    // Open-load detection in the off state.
    // ------------------------------------------------------------------

    // The filter outlasts the output fall time, so a switch that has just
    // turned off is not misread as open while its voltage decays.
    for (genvar i = 0; i < N_OUT; i++) begin : g_ol
        logic [QUAL_W-1:0] cnt_r, cnt_nxt;
        logic              hit;

        always_comb begin
            hit     = 1'b0;
            cnt_nxt = cnt_r;
            if (sw[i] || !open_load_above[i]) begin
                cnt_nxt = '0;
            end else if (tick_r) begin
                if (cnt_r == QUAL_W'(OL_FILT_TICKS - 1)) begin
                    hit     = 1'b1;
                    cnt_nxt = '0;
                end else begin
                    cnt_nxt = cnt_r + 1'b1;
                end
            end
        end

        always_ff @(posedge ref_clk) begin
            if (!resetn) begin
                cnt_r <= '0;
            end else begin
                cnt_r <= cnt_nxt;
            end
        end

        // Only a fresh latch counts as an event.
        assign ol_set[i] = hit & ~ol_r[i];
    end

    // ------------------------------------------------------------------
    // Bus slave and register file.
    // ------------------------------------------------------------------

    assign ap_valid = hsel & htrans[1] & hready;

    // Writes land in the data phase. Reads are taken from the next values,
    // so a read right after a write to the same register sees the new data.
    always_comb begin
        wr_pend_nxt = ap_valid & hwrite;
        wr_addr_nxt = ap_valid ? haddr[7:0] : wr_addr_r;
        ctrl_nxt    = ctrl_r;
        pullup_nxt  = pullup_r;
        mask_nxt    = mask_r;
        w1c         = '0;
        clr_nxt     = 1'b0;
        if (wr_pend_r) begin
            unique case (wr_addr_r)
                OFS_CTRL:     ctrl_nxt   = hwdata[N_OUT-1:0];
                OFS_PULLUP:   pullup_nxt = hwdata[N_OUT-1:0];
                OFS_CLEAR:    clr_nxt    = hwdata[CLEAR_BIT];
                OFS_IRQ_STAT: w1c        = hwdata[NUM_EVT-1:0];
                OFS_IRQ_MASK: mask_nxt   = hwdata[NUM_EVT-1:0];
                default: begin
                end
            endcase
        end

        // A new open load in the clearing cycle survives the clear.
        ol_nxt = (ol_r & ~{N_OUT{clr_r}}) | ol_set;

        // Sticky event bits: a set in the same cycle beats the clear.
        istat_nxt = (istat_r & ~w1c) | {ol_set, sc_event};
        irq_nxt   = |(istat_nxt & mask_nxt);

        rdata_nxt = '0;
        if (ap_valid && !hwrite) begin
            unique case (haddr[7:0])
                OFS_CTRL:     rdata_nxt[N_OUT-1:0]   = ctrl_nxt;
                OFS_PULLUP:   rdata_nxt[N_OUT-1:0]   = pullup_nxt;
                OFS_FAULT:    rdata_nxt[NUM_EVT-1:0] = {ol_nxt, sc_fault};
                OFS_IRQ_STAT: rdata_nxt[NUM_EVT-1:0] = istat_nxt;
                OFS_IRQ_MASK: rdata_nxt[NUM_EVT-1:0] = mask_nxt;
                OFS_LIVE:     rdata_nxt[N_OUT-1:0]   = sw;
                default:      rdata_nxt = '0;
            endcase
        end
    end

    // Registers of the slave. The slave never stalls and always says OKAY.
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= '0;
            ctrl_r    <= CTRL_RST;
            pullup_r  <= PULLUP_RST;
            mask_r    <= MASK_RST;
            ol_r      <= '0;
            istat_r   <= '0;
            clr_r     <= 1'b0;
            irq_r     <= 1'b0;
            rdata_r   <= '0;
            rdy_r     <= 1'b1;
            resp_r    <= 1'b0;
        end else begin
            wr_pend_r <= wr_pend_nxt;
            wr_addr_r <= wr_addr_nxt;
            ctrl_r    <= ctrl_nxt;
            pullup_r  <= pullup_nxt;
            mask_r    <= mask_nxt;
            ol_r      <= ol_nxt;
            istat_r   <= istat_nxt;
            clr_r     <= clr_nxt;
            irq_r     <= irq_nxt;
            rdata_r   <= rdata_nxt;
            rdy_r     <= 1'b1;
            resp_r    <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, each straight from a flip-flop.
    // ------------------------------------------------------------------
    assign hrdata                  = rdata_r;
    assign hreadyout               = rdy_r;
    assign hresp                   = resp_r;
    assign switch_enable           = sw;
    assign open_load_pullup_enable = pullup_r;
    assign irq                     = irq_r;

endmodule
`default_nettype wire

// [hsf_supervisor_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module hsf_supervisor_assertions
    import hsf_pkg::*;
#(
    parameter int N_OUT = NUM_OUT
) (
    input  wire logic             ref_clk,
    input  wire logic             resetn,
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic             hready,
    input  wire logic [31:0]      hrdata,
    input  wire logic             hreadyout,
    input  wire logic             hresp,
    input  wire logic [N_OUT-1:0] over_current,
    input  wire logic [N_OUT-1:0] switch_enable
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    // ----------------------------------------------------------
    // Helper counters
    // ----------------------------------------------------------
    logic        take;
    logic        rd_take;
    logic [2:0]  since_wr_r, since_wr_nxt;
    logic [12:0] heat_r, heat_nxt, lamp_r, lamp_nxt;

    // A write may legally move a switch for a few cycles afterwards.
    always_comb begin
        take = hsel && htrans[1] && hready;
        rd_take = take && !hwrite;
        since_wr_nxt = (since_wr_r == 3'h7) ? 3'h7 : since_wr_r + 3'h1;
        if (take && hwrite) since_wr_nxt = 3'h0;
        heat_nxt = (over_current[0] && switch_enable[0])
                   ? heat_r + 13'h1 : 13'h0;
        lamp_nxt = ((over_current[N_OUT-1:1] & switch_enable[N_OUT-1:1]) != 0)
                   ? lamp_r + 13'h1 : 13'h0;
    end

    // Registers only; saturating at 7 marks "no recent write".
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            since_wr_r <= 3'h7;
            heat_r     <= 13'h0;
            lamp_r     <= 13'h0;
        end else begin
            since_wr_r <= since_wr_nxt;
            heat_r     <= heat_nxt;
            lamp_r     <= lamp_nxt;
        end
    end

    ready_okay_a: assert property (hreadyout && !hresp)
        else $error("bus slave waited or answered an error");
    rdata_idle_a: assert property (!rd_take |=> hrdata == 32'h0)
        else $error("read data not zero outside a read");
    rdata_upper_a: assert property (
        rd_take |=> hrdata[31:10] == 22'h0)
        else $error("unused read data bits set");
    unmapped_zero_a: assert property (
        rd_take && (haddr[7:0] >= 8'h1C || haddr[7:0] == OFS_CLEAR)
        |=> hrdata == 32'h0)
        else $error("write-only or unmapped place read non-zero");
    heater_limit_a: assert property (heat_r < 13'd560)
        else $error("heater over-current not shut down in time");
    heater_qual_a: assert property (
        $fell(switch_enable[0]) && since_wr_r > 3'h4
        |-> $past(heat_r) >= 13'd460)
        else $error("heater shut down before the delay ran out");
    lamp_limit_a: assert property (lamp_r < 13'd4700)
        else $error("lamp over-current not shut down in time");
    sw_rise_cause_a: assert property (
        (switch_enable & ~$past(switch_enable)) != 0
        |-> since_wr_r <= 3'h6)
        else $error("switch turned on without a write");
    sw_fall_cause_a: assert property (
        ($past(switch_enable) & ~switch_enable & ~$past(over_current)) != 0
        |-> since_wr_r <= 3'h6)
        else $error("switch turned off without cause");
endmodule

bind hsf_supervisor hsf_supervisor_assertions #(.N_OUT(N_OUT)) u_sva (
    .ref_clk(ref_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .over_current(over_current),
    .switch_enable(switch_enable));
`default_nettype wire

// [hsf_load_model.sv]
`timescale 1ns/1ps
`default_nettype none
module hsf_load_model
    import hsf_pkg::*;
(
    input  wire logic [NUM_OUT-1:0] switch_enable,
    input  wire logic [NUM_OUT-1:0] pullup_en,
    input  wire logic [NUM_OUT-1:0] short_gnd,
    input  wire logic [NUM_OUT-1:0] overload,
    input  wire logic [NUM_OUT-1:0] open_wire,
    output logic      [NUM_OUT-1:0] over_current,
    output logic      [NUM_OUT-1:0] short_volt_low,
    output logic      [NUM_OUT-1:0] open_load_above
);
    // Bulbs and heater: only a closed switch can draw current, and a
    // dead short holds the output low; without the pull-up an open
    // output sinks to ground through leakage, so it reads low.
    always_comb begin
        over_current    = switch_enable & (short_gnd | overload);
        short_volt_low  = ~switch_enable | short_gnd;
        open_load_above = ~switch_enable & open_wire & pullup_en;
    end
endmodule
`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; \
    if ((g) !== (e)) begin mismatches++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module testbench;
    import hsf_pkg::*;
    logic        ref_clk, resetn, hsel, hwrite, hreadyout, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata, rd, val;
    logic [1:0]  htrans;
    logic [4:0]  oc, vlow, olh, sw, pu, shrt, ovl, opn;
    int          mismatches, tests_run, cyc, ch;

    hsf_supervisor u_dut (.ref_clk(ref_clk), .resetn(resetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .over_current(oc),
        .short_volt_low(vlow), .open_load_above(olh), .switch_enable(sw),
        .open_load_pullup_enable(pu), .irq(irq));
    hsf_load_model u_load (.switch_enable(sw), .pullup_en(pu),
        .short_gnd(shrt), .overload(ovl), .open_wire(opn),
        .over_current(oc), .short_volt_low(vlow), .open_load_above(olh));

    // Clock and a hang guard well above the expected run length.
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 90000) begin
            mismatches++;
            results();
        end
    end

    // ----------------------------------------------------------
    // Bus tasks and expectations
    // ----------------------------------------------------------
    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // One single transfer; the request holds until ready is sampled.
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge ref_clk);
        hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic chk_rd(input string nm, input logic [7:0] a,
                          input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(nm, e, rd)
    endtask
    task automatic us(input int n);
        repeat (n * TICK_CYC) @(posedge ref_clk);
    endtask
    // Status reset, then acknowledge every interrupt event.
    task automatic clear_all();
        bus(1'b1, OFS_CLEAR, 32'h1);
        bus(1'b1, OFS_IRQ_STAT, 32'h3FF);
        us(1);
    endtask
    // Short faults sit in the low field, open-load faults above them.
    function automatic logic [31:0] fbit(input int c, input int open);
        return 32'h1 << (c + open * NUM_OUT);
    endfunction

    // ----------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------
    initial begin
        resetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0;
        hwrite = 1'b0; hwdata = 32'h0; shrt = 5'h00; ovl = 5'h00;
        opn = 5'h00; mismatches = 0; tests_run = 0; cyc = 0;
        rd = $urandom(32'h0A630068);
        repeat (12) @(posedge ref_clk);
        resetn <= 1'b1;
        chk_rd("pullup", OFS_PULLUP, 32'h1F);
        chk_rd("fault", OFS_FAULT, 32'h0);
        chk_rd("mask", OFS_IRQ_MASK, 32'h0);
        chk_rd("unmapped", 8'h1C, 32'h0);
        val = $urandom & 32'h1F;
        bus(1'b1, OFS_PULLUP, val);
        us(1);
        `CHK("pullup_pin", val[4:0], pu)
        bus(1'b1, OFS_PULLUP, 32'h1F);
        bus(1'b1, OFS_IRQ_MASK, 32'h3FF);
        // Heater: broken over-current pulses, then a held short.
        bus(1'b1, OFS_CTRL, 32'h1);
        repeat (2) begin
            shrt[0] <= 1'b1;
            us(18 + $urandom_range(0, 4));
            shrt[0] <= 1'b0;
            us(2);
        end
        `CHK("heater_gap", 1'b1, sw[0])
        shrt[0] <= 1'b1;
        us(22);
        `CHK("heater_qual", 1'b1, sw[0])
        us(8);
        `CHK("heater_off", 1'b0, sw[0])
        shrt[0] <= 1'b0;
        us(5);
        `CHK("heater_held", 1'b0, sw[0])
        `CHK("irq_on", 1'b1, irq)
        chk_rd("fault", OFS_FAULT, fbit(0, 0));
        clear_all();
        `CHK("heater_back", 1'b1, sw[0])
        `CHK("irq_off", 1'b0, irq)
        chk_rd("ctrl", OFS_CTRL, 32'h1);
        chk_rd("live", OFS_LIVE, 32'h1);
        bus(1'b1, OFS_CTRL, 32'h0);
        for (ch = 1; ch < NUM_OUT; ch++) begin
            // Lamp switched on into a short to ground.
            shrt[ch] <= 1'b1;
            bus(1'b1, OFS_CTRL, fbit(ch, 0));
            us(180);
            `CHK("lamp_start", 1'b1, sw[ch])
            us(30);
            `CHK("lamp_start_off", 1'b0, sw[ch])
            shrt[ch] <= 1'b0;
            us(5);
            `CHK("lamp_held", 1'b0, sw[ch])
            chk_rd("fault", OFS_FAULT, fbit(ch, 0));
            clear_all();
            // Past the start phase, over-current alone trips it.
            us(210 + $urandom_range(0, 20));
            ovl[ch] <= 1'b1;
            us(20);
            `CHK("lamp_on_qual", 1'b1, sw[ch])
            us(10);
            `CHK("lamp_on_off", 1'b0, sw[ch])
            ovl[ch] <= 1'b0;
            bus(1'b1, OFS_CTRL, 32'h0);
            clear_all();
            // Open load while the switch is off.
            opn[ch] <= 1'b1;
            us(102);
            chk_rd("open", OFS_FAULT, fbit(ch, 1));
            opn[ch] <= 1'b0;
            us(3);
            chk_rd("open_held", OFS_FAULT, fbit(ch, 1));
            clear_all();
            chk_rd("open_clr", OFS_FAULT, 32'h0);
        end
        // Heater treated as an LED output: pull-up off, no open load.
        bus(1'b1, OFS_PULLUP, 32'h1E);
        bus(1'b1, OFS_IRQ_MASK, 32'h0);
        opn[0] <= 1'b1;
        us(110);
        chk_rd("led_open", OFS_FAULT, 32'h0);
        bus(1'b1, OFS_PULLUP, 32'h1F);
        us(110);
        opn[0] <= 1'b0;
        chk_rd("stat", OFS_IRQ_STAT, fbit(0, 1));
        `CHK("irq_masked", 1'b0, irq)
        bus(1'b1, OFS_IRQ_MASK, fbit(0, 1));
        us(1);
        `CHK("irq_unmasked", 1'b1, irq)
        bus(1'b1, OFS_IRQ_STAT, fbit(0, 1));
        us(1);
        `CHK("irq_w1c", 1'b0, irq)
        results();
    end
endmodule
`default_nettype wire
